// file: hw/sqle_pkg.sv
// constants and types for the sequencer load engine
package sqle_pkg;

  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_LENGTH = 3'h1;
  localparam logic [2:0] IDX_POSITION = 3'h2;
  localparam logic [2:0] IDX_CONFIG = 3'h3;
  localparam logic [2:0] IDX_FILE_ADDR = 3'h4;
  localparam logic [2:0] IDX_FILE_DATA = 3'h5;
  localparam logic [2:0] IDX_MINOR = 3'h6;
  localparam int ADDR_W = 5;

  // status, config and minor word fields
  localparam int BIT_ENABLE = 15;
  localparam int BIT_FINISHED = 13;
  localparam int BIT_FAULT = 11;
  localparam int BIT_FOUND = 8;
  localparam int BIT_LONG = 0;
  localparam int BIT_MINOR = 0;

  // reset values
  localparam logic [15:0] LENGTH_RST = 16'h0001;
  localparam logic [15:0] POSITION_RST = 16'h0000;

  // sequencer limits
  localparam int FILE_DEPTH = 256;
  localparam logic [15:0] LENGTH_MAX = 16'h0100;
  localparam logic [15:0] POSITION_MAX = 16'h00ff;
  localparam logic [15:0] STEP_ONE = 16'h0001;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register decode results
  typedef enum {
    SEL_STATUS,
    SEL_LENGTH,
    SEL_POSITION,
    SEL_CONFIG,
    SEL_FILE_ADDR,
    SEL_FILE_DATA,
    SEL_MINOR,
    SEL_NONE
  } sqle_sel_e;

  // flags held in the status word
  typedef struct packed {
    logic enable;
    logic finished;
    logic fault;
  } sqle_flags_s;

endpackage

// file: hw/sqle_top.sv
// sequencer load engine with an axi4-lite register slave
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

// What this block does
// R1: on each rung rise, write source into file element at current position
// R2: executive must give source the same size as the file
// R3: word sources are sign-extended 16-bit; long sources are full 32-bit
// R4: state lives in status, length and position 16-bit words
// R5: enable flag, bit 15, set on rung rise
// R6: finished flag, bit 13, set after last element; cleared on next rise
// R7: fault flag, bit 11, on bad position or length; minor error too
// R8: length is index of last element, valid 1 through 256
// R9: a source file uses the same length as the sequencer file
// R10: position holds current step, 0 through 255, selects next element
// R11: position selects both destination and source file elements
// R12: position increments by one on each rise, before the write
// R13: after finished, next rise returns position to step one
// R14: no writes or position change while rung is steady; enable clears
// R15: a faulted rise writes nothing into the file
module sqle_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [sqle_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [sqle_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // ladder executive side
  input wire logic rung_cond,
  input wire logic [31:0] src_data,
  output logic [7:0] src_index,
  output logic minor_error,
  output logic load_strobe
);

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  function automatic sqle_pkg::sqle_sel_e decode_sel(
    input logic [sqle_pkg::ADDR_W-1:0] addr
  );
    sqle_pkg::sqle_sel_e s;
    s = sqle_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0)
    begin
      case (addr[4:2])
        sqle_pkg::IDX_STATUS: s = sqle_pkg::SEL_STATUS;
        sqle_pkg::IDX_LENGTH: s = sqle_pkg::SEL_LENGTH;
        sqle_pkg::IDX_POSITION: s = sqle_pkg::SEL_POSITION;
        sqle_pkg::IDX_CONFIG: s = sqle_pkg::SEL_CONFIG;
        sqle_pkg::IDX_FILE_ADDR: s = sqle_pkg::SEL_FILE_ADDR;
        sqle_pkg::IDX_FILE_DATA: s = sqle_pkg::SEL_FILE_DATA;
        sqle_pkg::IDX_MINOR: s = sqle_pkg::SEL_MINOR;
        default: s = sqle_pkg::SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [sqle_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  sqle_pkg::sqle_flags_s flags_q;
  logic [15:0] length_q, position_q;
  logic long_q, minor_q, rung_prev_q, load_q;
  logic [7:0] file_addr_q, src_index_q;
  logic [31:0] seq_file [sqle_pkg::FILE_DEPTH];

  logic aw_held, w_held, do_write, rise, bad, sw_wr;
  logic [15:0] step;
  logic [31:0] load_val;
  sqle_pkg::sqle_sel_e wsel;

  assign aw_held = !awready_q;
  assign w_held = !wready_q;
  assign do_write = aw_held && w_held && !bvalid_q;
  assign wsel = decode_sel(aw_addr_q);
  assign sw_wr = do_write && w_strb_q[0] && w_strb_q[1];
  assign rise = rung_cond && !rung_prev_q;

  // R13: step one after finished, else one past position
  // R12: position advances before the write
  assign step = flags_q.finished ? sqle_pkg::STEP_ONE
                                 : 16'(position_q + 16'h0001);

  // R7: negative position or non-positive length
  // R8: length beyond 256, R10: step beyond 255
  assign bad = ($signed(length_q) <= 16'sh0000)
            || (length_q > sqle_pkg::LENGTH_MAX)
            || ($signed(position_q) < 16'sh0000)
            || (step > sqle_pkg::POSITION_MAX);

  // R3: word source is sign-extended, long word taken whole
  assign load_val = long_q ? src_data : {{16{src_data[15]}}, src_data[15:0]};

  // ------------------------------------------------------------
  // write channels
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      aw_addr_q <= '0;
    end
    else if (awvalid && awready_q)
    begin
      awready_q <= 1'b0;
      aw_addr_q <= awaddr;
    end
    else if (bvalid_q && bready)
      awready_q <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_q <= 1'b1;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (wvalid && wready_q)
    begin
      wready_q <= 1'b0;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end
    else if (bvalid_q && bready)
      wready_q <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= sqle_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wsel == sqle_pkg::SEL_NONE) ? sqle_pkg::RESP_SLVERR
                                               : sqle_pkg::RESP_OKAY;
    end
    else if (bvalid_q && bready)
      bvalid_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // read channels
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= sqle_pkg::RESP_OKAY;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= sqle_pkg::RESP_OKAY;
      rdata_q <= '0;
      case (decode_sel(araddr))
        sqle_pkg::SEL_STATUS:
        begin
          rdata_q[sqle_pkg::BIT_ENABLE] <= flags_q.enable;
          rdata_q[sqle_pkg::BIT_FINISHED] <= flags_q.finished;
          rdata_q[sqle_pkg::BIT_FAULT] <= flags_q.fault;
        end
        sqle_pkg::SEL_LENGTH: rdata_q[15:0] <= length_q;
        sqle_pkg::SEL_POSITION: rdata_q[15:0] <= position_q;
        sqle_pkg::SEL_CONFIG: rdata_q[sqle_pkg::BIT_LONG] <= long_q;
        sqle_pkg::SEL_FILE_ADDR: rdata_q[7:0] <= file_addr_q;
        sqle_pkg::SEL_FILE_DATA: rdata_q <= seq_file[file_addr_q];
        sqle_pkg::SEL_MINOR: rdata_q[sqle_pkg::BIT_MINOR] <= minor_q;
        default: rresp_q <= sqle_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid_q && rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // configuration
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      long_q <= 1'b0;
      file_addr_q <= '0;
    end
    else if (do_write && w_strb_q[0])
    begin
      if (wsel == sqle_pkg::SEL_CONFIG)
        long_q <= w_data_q[sqle_pkg::BIT_LONG];
      if (wsel == sqle_pkg::SEL_FILE_ADDR)
        file_addr_q <= w_data_q[7:0];
    end
  end

  // ------------------------------------------------------------
  // sequencer engine
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rung_prev_q <= 1'b0;
    else
      rung_prev_q <= rung_cond;
  end

  // R4: control element words
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      length_q <= sqle_pkg::LENGTH_RST;
      position_q <= sqle_pkg::POSITION_RST;
    end
    // R12: advance on rise unless faulted
    else if (rise && !bad)
      position_q <= step;
    // R14: otherwise only software moves the words
    else if (sw_wr)
    begin
      if (wsel == sqle_pkg::SEL_LENGTH)
        length_q <= w_data_q[15:0];
      if (wsel == sqle_pkg::SEL_POSITION)
        position_q <= w_data_q[15:0];
    end
  end

  // flags: a hardware set wins over a software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_q <= '0;
    else
    begin
      // R5: enable follows the rise; R14: clears while rung false
      flags_q.enable <= rise ? 1'b1 : (flags_q.enable && rung_cond);
      // R6: finished at last element, cleared on the following rise
      if (rise)
        flags_q.finished <= !bad && (step >= length_q);
      else if (do_write && wsel == sqle_pkg::SEL_STATUS && w_strb_q[1])
        flags_q.finished <= w_data_q[sqle_pkg::BIT_FINISHED];
      // R7: fault on bad length or position
      if (rise && bad)
        flags_q.fault <= 1'b1;
      else if (rise)
        flags_q.fault <= 1'b0;
      else if (do_write && wsel == sqle_pkg::SEL_STATUS && w_strb_q[1])
        flags_q.fault <= w_data_q[sqle_pkg::BIT_FAULT];
    end
  end

  // R7: global minor error, write one to clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      minor_q <= 1'b0;
    else if (rise && bad)
      minor_q <= 1'b1;
    else if (do_write && w_strb_q[0] && wsel == sqle_pkg::SEL_MINOR
             && w_data_q[sqle_pkg::BIT_MINOR])
      minor_q <= 1'b0;
  end

  // R1: load source into the file
  // R15: faulted rise writes nothing
  always_ff @(posedge aclk)
  begin
    if (rise && !bad)
      seq_file[step[7:0]] <= load_val;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      load_q <= 1'b0;
    else
      load_q <= rise && !bad;
  end

  // R11: source element index for the next rise
  // R9: same length governs the source file
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      src_index_q <= '0;
    else
      src_index_q <= step[7:0];
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign src_index = src_index_q;
  assign minor_error = minor_q;
  assign load_strobe = load_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_enable_rise;
    rise |=> flags_q.enable;
  endproperty
  a_enable_rise: assert property (p_enable_rise) // R5
    else $error("enable not set after rung rise");

  property p_enable_clear;
    !rung_cond && !rise |=> !flags_q.enable;
  endproperty
  a_enable_clear: assert property (p_enable_clear) // R14
    else $error("enable held while rung false");

  property p_step_inc;
    rise && !bad && !flags_q.finished
      |=> position_q == 16'($past(position_q) + 16'h0001);
  endproperty
  a_step_inc: assert property (p_step_inc) // R12
    else $error("position did not advance by one");

  property p_wrap_one;
    rise && !bad && flags_q.finished |=> position_q == sqle_pkg::STEP_ONE;
  endproperty
  a_wrap_one: assert property (p_wrap_one) // R13
    else $error("position not returned to step one");

  property p_fault_minor;
    rise && bad |=> flags_q.fault && minor_q && !load_q;
  endproperty
  a_fault_minor: assert property (p_fault_minor) // R7
    else $error("fault without minor error or with a load");

  property p_no_load_fault;
    load_q |-> !flags_q.fault;
  endproperty
  a_no_load_fault: assert property (p_no_load_fault) // R15
    else $error("file loaded on a faulted rise");

  property p_steady;
    !rise && !sw_wr |=> $stable(position_q) && !load_q;
  endproperty
  a_steady: assert property (p_steady) // R14
    else $error("position moved while rung steady");

  property p_finished;
    rise && !bad && step == length_q |=> flags_q.finished ##1 1'b1;
  endproperty
  a_finished: assert property (p_finished) // R6
    else $error("finished flag missing at last element");

  property p_len_range;
    rise && length_q > sqle_pkg::LENGTH_MAX |=> flags_q.fault;
  endproperty
  a_len_range: assert property (p_len_range) // R8
    else $error("length above 256 accepted");

  c_load: cover property (rise && !bad ##1 load_q);
  c_wrap: cover property (rise && flags_q.finished && !bad);
  c_fault: cover property (rise && bad);
  c_long: cover property (rise && long_q && !bad);

endmodule

// file: testbench/sqle_exec_model.sv
// ladder executive model: rung condition and source file
`timescale 1ns/1ps

module sqle_exec_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench control
  input wire logic want,
  input wire logic long_mode,
  input wire logic [31:0] base,
  // engine side
  input wire logic [7:0] src_index,
  output logic rung_cond,
  output logic [31:0] src_data
);
  logic [15:0] w;

  assign w = base[15:0] + {8'h00, src_index};
  assign src_data = long_mode ? base + {24'h0, src_index} : {{16{w[15]}}, w};

  // rung follows the scan one cycle late
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rung_cond <= 1'b0;
    else
      rung_cond <= want;
  end
endmodule

// file: testbench/sqle_top_tb.sv
// self-checking bench for the sequencer load engine
`timescale 1ns/1ps

module sqle_top_tb;
  localparam logic [4:0] L_ST = {sqle_pkg::IDX_STATUS, 2'b00};
  localparam logic [4:0] L_LEN = {sqle_pkg::IDX_LENGTH, 2'b00};
  localparam logic [4:0] L_POS = {sqle_pkg::IDX_POSITION, 2'b00};
  localparam logic [4:0] L_CFG = {sqle_pkg::IDX_CONFIG, 2'b00};
  localparam logic [4:0] L_FA = {sqle_pkg::IDX_FILE_ADDR, 2'b00};
  localparam logic [4:0] L_FDATA = {sqle_pkg::IDX_FILE_DATA, 2'b00};
  localparam logic [4:0] L_MIN = {sqle_pkg::IDX_MINOR, 2'b00};
  localparam logic [1:0] OK = sqle_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = sqle_pkg::RESP_SLVERR;
  logic aclk;
  logic aresetn;
  logic [4:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, src_data, base, lfsr_q;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic rung_cond, want, long_mode, minor_error, load_strobe;
  logic [7:0] src_index;
  logic [34:0] re;
  logic [31:0] bad_len [3] = '{32'h0, 32'h101, 32'h3};
  logic [31:0] bad_pos [3] = '{32'h1, 32'h1, 32'hffff};
  int fails, tests_run, strobes;
  logic [1:0] bq[$];
  logic [34:0] rq[$];

  sqle_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .rung_cond(rung_cond),
    .src_data(src_data), .src_index(src_index),
    .minor_error(minor_error), .load_strobe(load_strobe));

  sqle_exec_model u_exec (.aclk(aclk), .aresetn(aresetn), .want(want),
    .long_mode(long_mode), .base(base), .src_index(src_index),
    .rung_cond(rung_cond), .src_data(src_data));

  always #4 aclk = ~aclk;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] sv(input logic [7:0] k);
    logic [15:0] w;
    w = base[15:0] + {8'h00, k};
    return long_mode ? base + {24'h0, k} : {{16{w[15]}}, w};
  endfunction

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] e);
    logic bd;
    bd = 1'b0;
    bq.push_back(e);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bd)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        bd = 1'b1;
        bready <= 1'b0;
      end
    end
    // one idle edge so the next call never re-drives bready in this step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic c, input logic [1:0] r);
    logic got;
    got = 1'b0;
    rq.push_back({c, r, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        got = 1'b1;
        rready <= 1'b0;
      end
    end
    // one idle edge so the next call never re-drives rready in this step
    @(posedge aclk);
  endtask

  // one rung pulse; status read while rung is true
  task automatic rise(input logic [31:0] st);
    want <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(L_ST, st, 1'b1, OK);
    want <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic fchk(input logic [7:0] k, input logic [31:0] e);
    wr(L_FA, {24'h0, k}, 4'hf, OK);
    rd(L_FDATA, e, 1'b1, OK);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // output monitor
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (bvalid === 1'b1 && bready === 1'b1)
      chk("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
    if (rvalid === 1'b1 && rready === 1'b1)
    begin
      re = rq.pop_front();
      chk("rresp", {30'h0, rresp}, {30'h0, re[33:32]});
      if (re[34])
        chk("rdata", rdata, re[31:0]);
    end
    if (load_strobe === 1'b1)
      strobes++;
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    aclk = 0; aresetn = 0; awaddr = 0; araddr = 0; awprot = 0; arprot = 0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    wdata = 0; wstrb = 0; want = 0; long_mode = 0; base = 0;
    lfsr_q = 32'h321174cc; fails = 0; tests_run = 0; strobes = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(L_ST, 32'h0, 1'b1, OK);
    rd(L_LEN, 32'h1, 1'b1, OK);
    rd(L_POS, 32'h0, 1'b1, OK);
    rd(5'h1c, 32'h0, 1'b0, ERR);
    rd(5'h01, 32'h0, 1'b0, ERR);
    wr(5'h1c, 32'h0, 4'hf, ERR);
    lfsr_q = lfsr(lfsr(lfsr_q));
    base <= {lfsr_q[31:16], 1'b1, lfsr_q[14:0]};
    wr(L_LEN, 32'h3, 4'h1, OK);
    rd(L_LEN, 32'h1, 1'b1, OK);
    wr(L_LEN, 32'h3, 4'hf, OK);
    rise(32'h8000);
    rise(32'h8000);
    rise(32'ha000);
    rd(L_ST, 32'h2000, 1'b1, OK);
    rd(L_POS, 32'h3, 1'b1, OK);
    chk("src_index", {24'h0, src_index}, 32'h1);
    for (int k = 1; k < 4; k++)
      fchk(k[7:0], sv(k[7:0]));
    chk("strobes", strobes, 3);
    wr(L_FDATA, 32'h0, 4'hf, OK);
    fchk(8'h3, sv(8'h3));
    rise(32'h8000);
    rd(L_POS, 32'h1, 1'b1, OK);
    for (int i = 0; i < 3; i++)
    begin
      wr(L_LEN, bad_len[i], 4'hf, OK);
      wr(L_POS, bad_pos[i], 4'hf, OK);
      rise(32'h8800);
      rd(L_POS, bad_pos[i], 1'b1, OK);
      chk("minor", {31'h0, minor_error}, 32'h1);
    end
    chk("strobes", strobes, 4);
    wr(L_MIN, 32'h1, 4'hf, OK);
    chk("minor", {31'h0, minor_error}, 32'h0);
    // long words up to both signed ends
    long_mode <= 1'b1;
    base <= 32'h7fffff01;
    wr(L_CFG, 32'h1, 4'hf, OK);
    wr(L_LEN, 32'hff, 4'hf, OK);
    wr(L_POS, 32'hfd, 4'hf, OK);
    rise(32'h8000);
    rise(32'ha000);
    fchk(8'hfe, 32'h7fffffff);
    fchk(8'hff, 32'h80000000);
    rise(32'h8000);
    rd(L_POS, 32'h1, 1'b1, OK);
    fchk(8'h1, sv(8'h1));
    chk("src_index", {24'h0, src_index}, 32'h2);
    chk("strobes", strobes, 7);
    summarize();
  end
endmodule
